// [lue_pkg.sv]
// Package with register map, field layout and carrier types for the lookup index block.
`default_nettype none
package lue_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] OFF_AF_WF_INDEX = 16'h0316;
  localparam logic [15:0] OFF_LEARN_FAIL_INDEX = 16'h0318;
  localparam logic [15:0] OFF_HOST_ACCESS_INDEX = 16'h031a;
  localparam logic [15:0] OFF_UNK_UC_CTRL = 16'h0320;
  localparam logic [15:0] OFF_UNK_MC_CTRL = 16'h0324;
  localparam logic [15:0] OFF_UNK_VID_CTRL = 16'h0328;
  localparam int ENTRY_W = 12;
  localparam int BUCKET_W = 10;
  localparam int NPORTS = 3;
  localparam int FWD_EN_BIT = 31;
  localparam logic [1:0] AF_MIN_STATIC = 2'h2;
  localparam logic [2:0] FULL_STATIC = 3'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] INDEX_RESET = 16'h0000;

  typedef struct packed {
    logic en;
    logic [NPORTS-1:0] ports;
  } fwd_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Lookup engine event report: one-cycle strobes with the addresses involved.
  typedef struct packed {
    logic static_wr_ok;
    logic [2:0] prior_static;
    logic [ENTRY_W-1:0] entry_addr;
    logic static_wr_fail;
    logic learn_fail;
    logic [2:0] learn_static;
    logic host_access;
    logic [BUCKET_W-1:0] bucket_addr;
  } lue_event_t;

  typedef struct packed {
    logic unk_vid;
    logic unk_uc;
    logic unk_mc;
  } pkt_class_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_VID = 2'b01,
    SEL_UC = 2'b10,
    SEL_MC = 2'b11
  } fwd_sel_t;
endpackage
`default_nettype wire

// [unknown_fwd_select.sv]
// Picks the forwarding map for a packet that falls into unknown categories.
`timescale 1ns/1ps
`default_nettype none
module unknown_fwd_select (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire lue_pkg::pkt_class_t i_class,
  input wire lue_pkg::fwd_ctrl_t i_vid,
  input wire lue_pkg::fwd_ctrl_t i_uc,
  input wire lue_pkg::fwd_ctrl_t i_mc,
  output logic o_valid,
  output lue_pkg::fwd_sel_t o_sel,
  output logic o_fwd_en,
  output logic [lue_pkg::NPORTS-1:0] o_ports
);
  lue_pkg::fwd_sel_t sel_d;
  lue_pkg::fwd_ctrl_t ctl_d;

  // Only the winning category's control is used, even when it is disabled.
  always_comb begin
    sel_d = lue_pkg::SEL_NONE;
    ctl_d = '0;
    if (i_class.unk_vid) begin
      sel_d = lue_pkg::SEL_VID;
      ctl_d = i_vid;
    end else if (i_class.unk_uc) begin
      sel_d = lue_pkg::SEL_UC;
      ctl_d = i_uc;
    end else if (i_class.unk_mc) begin
      sel_d = lue_pkg::SEL_MC;
      ctl_d = i_mc;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_sel <= lue_pkg::SEL_NONE;
      o_fwd_en <= 1'b0;
      o_ports <= '0;
    end else if (i_ce) begin
      o_valid <= i_valid;
      o_sel <= sel_d;
      o_fwd_en <= ctl_d.en;
      o_ports <= ctl_d.en ? ctl_d.ports : '0;
    end
  end
endmodule // unknown_fwd_select
`default_nettype wire

// [lookup_index_unknown_fwd.sv]
// Lookup engine index capture and unknown-destination forwarding control registers.
// Operation
// - Almost-full static write with no failed write in the same cycle records 12-bit entry address.
// - Failed static write records 10-bit bucket address.
// - Learn failure on full-static bucket records bucket.
// - Every host table access records its bucket.
// - Precedence: unknown VID, unicast, then multicast.
// - Unicast bit 31 enables unknown unicast forwarding.
// - Unicast bits 2..0 select ports 3..1.
// - Multicast bit 31 enables unknown multicast forwarding.
// - Multicast bits 2..0 select ports 3..1.
// - Unicast control resets to zero.
// - Multicast control resets to zero.
// - Almost-full write raises almost-full status.
// - Unknown VID control enables and ranks first.
`timescale 1ns/1ps
`default_nettype none
module lookup_index_unknown_fwd (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire lue_pkg::reg_req_t i_req,
  output logic [lue_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_rerr,
  input wire lue_pkg::lue_event_t i_event,
  output logic o_almost_full_evt,
  input wire logic i_pkt_valid,
  input wire lue_pkg::pkt_class_t i_pkt_class,
  output logic o_fwd_valid,
  output lue_pkg::fwd_sel_t o_fwd_sel,
  output logic o_fwd_en,
  output logic [lue_pkg::NPORTS-1:0] o_fwd_ports
);
  logic [15:0] af_wf_index_q;
  logic [15:0] learn_fail_index_q;
  logic [15:0] host_access_index_q;
  lue_pkg::fwd_ctrl_t uc_ctrl_q;
  lue_pkg::fwd_ctrl_t mc_ctrl_q;
  lue_pkg::fwd_ctrl_t vid_ctrl_q;
  logic almost_full_hit;

  function automatic lue_pkg::fwd_ctrl_t ctrl_from_word(input logic [31:0] w);
    ctrl_from_word.en = w[lue_pkg::FWD_EN_BIT];
    ctrl_from_word.ports = w[lue_pkg::NPORTS-1:0];
  endfunction

  function automatic logic [31:0] ctrl_to_word(input lue_pkg::fwd_ctrl_t c);
    ctrl_to_word = lue_pkg::CTRL_RESET;
    ctrl_to_word[lue_pkg::FWD_EN_BIT] = c.en;
    ctrl_to_word[lue_pkg::NPORTS-1:0] = c.ports;
  endfunction

  assign almost_full_hit = i_event.static_wr_ok &&
    (i_event.prior_static == {1'b0, lue_pkg::AF_MIN_STATIC} ||
     i_event.prior_static == {1'b0, lue_pkg::AF_MIN_STATIC} + 3'h1);

  // A failed write and an almost-full write share one register; the failure is
  // the rarer and more urgent report, so it wins if both ever arrive together.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      af_wf_index_q <= lue_pkg::INDEX_RESET;
    end else if (i_ce) begin
      if (i_event.static_wr_fail) begin
        af_wf_index_q <= {6'h00, i_event.bucket_addr};
      end else if (almost_full_hit) begin
        af_wf_index_q <= {4'h0, i_event.entry_addr};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      learn_fail_index_q <= lue_pkg::INDEX_RESET;
    end else if (i_ce && i_event.learn_fail && i_event.learn_static == lue_pkg::FULL_STATIC) begin
      learn_fail_index_q <= {6'h00, i_event.bucket_addr};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      host_access_index_q <= lue_pkg::INDEX_RESET;
    end else if (i_ce && i_event.host_access) begin
      host_access_index_q <= {6'h00, i_event.bucket_addr};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_almost_full_evt <= 1'b0;
    end else if (i_ce) begin
      o_almost_full_evt <= almost_full_hit;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      uc_ctrl_q <= ctrl_from_word(lue_pkg::CTRL_RESET);
      mc_ctrl_q <= ctrl_from_word(lue_pkg::CTRL_RESET);
      vid_ctrl_q <= ctrl_from_word(lue_pkg::CTRL_RESET);
    end else if (i_ce && i_req.wr) begin
      case (i_req.addr)
        lue_pkg::OFF_UNK_UC_CTRL: uc_ctrl_q <= ctrl_from_word(i_req.wdata);
        lue_pkg::OFF_UNK_MC_CTRL: mc_ctrl_q <= ctrl_from_word(i_req.wdata);
        lue_pkg::OFF_UNK_VID_CTRL: vid_ctrl_q <= ctrl_from_word(i_req.wdata);
        default: ;
      endcase
    end
  end

  // Reads have no side effect; captured indices are never cleared by software.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_rvalid <= 1'b0;
      o_rerr <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      o_rerr <= 1'b0;
      if (i_req.rd) begin
        case (i_req.addr)
          lue_pkg::OFF_AF_WF_INDEX: o_rdata <= {16'h0000, af_wf_index_q};
          lue_pkg::OFF_LEARN_FAIL_INDEX: o_rdata <= {16'h0000, learn_fail_index_q};
          lue_pkg::OFF_HOST_ACCESS_INDEX: o_rdata <= {16'h0000, host_access_index_q};
          lue_pkg::OFF_UNK_UC_CTRL: o_rdata <= ctrl_to_word(uc_ctrl_q);
          lue_pkg::OFF_UNK_MC_CTRL: o_rdata <= ctrl_to_word(mc_ctrl_q);
          lue_pkg::OFF_UNK_VID_CTRL: o_rdata <= ctrl_to_word(vid_ctrl_q);
          default: begin
            o_rdata <= '0;
            o_rerr <= 1'b1;
          end
        endcase
      end
    end
  end

  unknown_fwd_select u_sel (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_pkt_valid),
    .i_class(i_pkt_class),
    .i_vid(vid_ctrl_q),
    .i_uc(uc_ctrl_q),
    .i_mc(mc_ctrl_q),
    .o_valid(o_fwd_valid),
    .o_sel(o_fwd_sel),
    .o_fwd_en(o_fwd_en),
    .o_ports(o_fwd_ports)
  );

  a_af_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && almost_full_hit && !i_event.static_wr_fail |=>
      af_wf_index_q == {4'h0, $past(i_event.entry_addr)})
    else $error("almost-full index not captured");
  a_wf_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_event.static_wr_fail |=> af_wf_index_q == {6'h00, $past(i_event.bucket_addr)})
    else $error("write-fail index not captured");
  a_learn_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_event.learn_fail && i_event.learn_static == lue_pkg::FULL_STATIC |=>
      learn_fail_index_q == {6'h00, $past(i_event.bucket_addr)})
    else $error("learn-fail index not captured");
  a_host_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_event.host_access |=> host_access_index_q == {6'h00, $past(i_event.bucket_addr)})
    else $error("host access index not captured");
  a_vid_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_pkt_class.unk_vid |=> o_fwd_sel == lue_pkg::SEL_VID && o_fwd_en == $past(vid_ctrl_q.en))
    else $error("unknown VID did not take precedence");
  a_uc_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && !i_pkt_class.unk_vid && i_pkt_class.unk_uc |=>
      o_fwd_sel == lue_pkg::SEL_UC && o_fwd_ports == ($past(uc_ctrl_q.en) ? $past(uc_ctrl_q.ports) : 3'h0))
    else $error("unknown unicast forwarding wrong");
  a_mc_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_pkt_class == 3'b001 |=>
      o_fwd_sel == lue_pkg::SEL_MC && o_fwd_ports == ($past(mc_ctrl_q.en) ? $past(mc_ctrl_q.ports) : 3'h0))
    else $error("unknown multicast forwarding wrong");
  a_ctrl_reset: assert property (@(posedge i_sys_clk)
    $past(i_rst) |-> uc_ctrl_q == '0 && mc_ctrl_q == '0)
    else $error("control registers not zero after reset");
  a_af_status: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce |=> o_almost_full_evt == $past(almost_full_hit))
    else $error("almost-full status wrong");
  a_index_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_event.learn_fail |=> $stable(learn_fail_index_q))
    else $error("learn-fail index changed without event");

  // The other two captures must also sit still between their own events, so that
  // software polling a register never sees an address from an unrelated cycle.
  a_host_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_event.host_access |=> $stable(host_access_index_q))
    else $error("host access index changed without event");
  a_af_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_event.static_wr_fail && !almost_full_hit |=> $stable(af_wf_index_q))
    else $error("almost-full index changed without event");
  a_mc_ctrl_reset: assert property (@(posedge i_sys_clk)
    $past(i_rst) |-> mc_ctrl_q.en == 1'b0 && mc_ctrl_q.ports == '0)
    else $error("multicast control not zero after reset");

  // Reserved control bits must read zero whatever software wrote into them.
  a_uc_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_req.rd && i_req.addr == lue_pkg::OFF_UNK_UC_CTRL |=>
      o_rdata[lue_pkg::FWD_EN_BIT] == $past(uc_ctrl_q.en) &&
      o_rdata[lue_pkg::FWD_EN_BIT-1:lue_pkg::NPORTS] == '0 &&
      o_rdata[lue_pkg::NPORTS-1:0] == $past(uc_ctrl_q.ports))
    else $error("unicast control read back wrong");
  a_mc_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_req.rd && i_req.addr == lue_pkg::OFF_UNK_MC_CTRL |=>
      o_rdata[lue_pkg::FWD_EN_BIT] == $past(mc_ctrl_q.en) &&
      o_rdata[lue_pkg::FWD_EN_BIT-1:lue_pkg::NPORTS] == '0 &&
      o_rdata[lue_pkg::NPORTS-1:0] == $past(mc_ctrl_q.ports))
    else $error("multicast control read back wrong");

  // Main scenarios that the bench is expected to reach.
  c_uc_fwd: cover property (@(posedge i_sys_clk) o_fwd_sel == lue_pkg::SEL_UC && o_fwd_en);
  c_fail_beats_af: cover property (@(posedge i_sys_clk)
    i_ce && i_event.static_wr_fail && almost_full_hit);
  c_vid_over_uc: cover property (@(posedge i_sys_clk)
    i_ce && i_pkt_class.unk_vid && i_pkt_class.unk_uc);
  c_af_write: cover property (@(posedge i_sys_clk) o_almost_full_evt);
  c_bad_read: cover property (@(posedge i_sys_clk) o_rerr);
endmodule // lookup_index_unknown_fwd
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the lookup index and unknown forwarding block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  lue_pkg::reg_req_t i_req = '0;
  lue_pkg::lue_event_t i_event = '0;
  logic i_pkt_valid = 1'b0;
  lue_pkg::pkt_class_t i_pkt_class = '0;
  logic [31:0] o_rdata;
  logic o_rvalid;
  logic o_rerr;
  logic o_almost_full_evt;
  logic o_fwd_valid;
  lue_pkg::fwd_sel_t o_fwd_sel;
  logic o_fwd_en;
  logic [2:0] o_fwd_ports;
  int errors = 0;
  int n_compared = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  lookup_index_unknown_fwd dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rerr(o_rerr), .i_event(i_event),
    .o_almost_full_evt(o_almost_full_evt), .i_pkt_valid(i_pkt_valid),
    .i_pkt_class(i_pkt_class), .o_fwd_valid(o_fwd_valid), .o_fwd_sel(o_fwd_sel),
    .o_fwd_en(o_fwd_en), .o_fwd_ports(o_fwd_ports)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_sys_clk);
    i_req.wr = 1'b1;
    i_req.addr = a;
    i_req.wdata = d;
    @(negedge i_sys_clk);
    i_req.wr = 1'b0;
  endtask

  // The answer is registered, so it is judged one cycle after the request edge.
  task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp, input logic err);
    @(negedge i_sys_clk);
    i_req.rd = 1'b1;
    i_req.addr = a;
    @(negedge i_sys_clk);
    i_req.rd = 1'b0;
    chk({30'h0, o_rvalid, o_rerr}, {30'h0, 1'b1, err}, "read answer flags");
    chk(o_rdata, exp, "read data");
  endtask

  task automatic ev(input lue_pkg::lue_event_t e, input logic af);
    @(negedge i_sys_clk);
    i_event = e;
    @(negedge i_sys_clk);
    i_event = '0;
    chk({31'h0, o_almost_full_evt}, {31'h0, af}, "almost full pulse");
  endtask

  task automatic fwd(input logic [2:0] cls, input logic [1:0] sel, input logic en,
                     input logic [2:0] ports);
    @(negedge i_sys_clk);
    i_pkt_valid = 1'b1;
    i_pkt_class = lue_pkg::pkt_class_t'(cls);
    @(negedge i_sys_clk);
    chk({25'h0, o_fwd_valid, o_fwd_sel, o_fwd_en, o_fwd_ports},
        {25'h0, 1'b1, sel, en, ports}, "forward decision");
  endtask

  task automatic test_reset();
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_LEARN_FAIL_INDEX, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_HOST_ACCESS_INDEX, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_UNK_UC_CTRL, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_UNK_MC_CTRL, 32'h0000_0000, 1'b0);
    reg_rd(16'h0330, 32'h0000_0000, 1'b1);
    $display("test_reset done");
  endtask

  task automatic test_ctrl();
    reg_wr(lue_pkg::OFF_UNK_UC_CTRL, 32'hffff_ffff);
    reg_rd(lue_pkg::OFF_UNK_UC_CTRL, 32'h8000_0007, 1'b0);
    reg_wr(lue_pkg::OFF_UNK_MC_CTRL, 32'h7fff_fffa);
    reg_rd(lue_pkg::OFF_UNK_MC_CTRL, 32'h0000_0002, 1'b0);
    reg_wr(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_ffff);
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_0000, 1'b0);
    // A frozen clock enable must keep a write from landing.
    @(negedge i_sys_clk);
    i_ce = 1'b0;
    reg_wr(lue_pkg::OFF_UNK_UC_CTRL, 32'h0000_0000);
    @(negedge i_sys_clk);
    i_ce = 1'b1;
    reg_rd(lue_pkg::OFF_UNK_UC_CTRL, 32'h8000_0007, 1'b0);
    $display("test_ctrl done");
  endtask

  task automatic test_events();
    ev('{static_wr_ok: 1'b1, prior_static: 3'h2, entry_addr: 12'habc, default: '0}, 1'b1);
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_0abc, 1'b0);
    ev('{static_wr_ok: 1'b1, prior_static: 3'h3, entry_addr: 12'h123, default: '0}, 1'b1);
    ev('{static_wr_ok: 1'b1, prior_static: 3'h1, entry_addr: 12'hfff, default: '0}, 1'b0);
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_0123, 1'b0);
    ev('{static_wr_fail: 1'b1, bucket_addr: 10'h3ff, default: '0}, 1'b0);
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_03ff, 1'b0);
    // Both reports in one cycle: the failed bucket wins the shared register.
    ev('{static_wr_ok: 1'b1, prior_static: 3'h2, entry_addr: 12'h555,
         static_wr_fail: 1'b1, bucket_addr: 10'h111, default: '0}, 1'b1);
    reg_rd(lue_pkg::OFF_AF_WF_INDEX, 32'h0000_0111, 1'b0);
    ev('{learn_fail: 1'b1, learn_static: 3'h4, bucket_addr: 10'h155, default: '0}, 1'b0);
    ev('{learn_fail: 1'b1, learn_static: 3'h3, bucket_addr: 10'h0aa, default: '0}, 1'b0);
    reg_rd(lue_pkg::OFF_LEARN_FAIL_INDEX, 32'h0000_0155, 1'b0);
    ev('{host_access: 1'b1, bucket_addr: 10'h2aa, default: '0}, 1'b0);
    reg_rd(lue_pkg::OFF_HOST_ACCESS_INDEX, 32'h0000_02aa, 1'b0);
    reg_rd(lue_pkg::OFF_LEARN_FAIL_INDEX, 32'h0000_0155, 1'b0);
    reg_rd(lue_pkg::OFF_HOST_ACCESS_INDEX, 32'h0000_02aa, 1'b0);
    $display("test_events done");
  endtask

  task automatic test_fwd();
    reg_wr(lue_pkg::OFF_UNK_UC_CTRL, 32'h8000_0005);
    reg_wr(lue_pkg::OFF_UNK_MC_CTRL, 32'h8000_0006);
    reg_wr(lue_pkg::OFF_UNK_VID_CTRL, 32'h0000_0003);
    reg_rd(lue_pkg::OFF_UNK_VID_CTRL, 32'h0000_0003, 1'b0);
    fwd(3'b001, 2'h3, 1'b1, 3'h6);
    fwd(3'b010, 2'h2, 1'b1, 3'h5);
    fwd(3'b011, 2'h2, 1'b1, 3'h5);
    fwd(3'b100, 2'h1, 1'b0, 3'h0);
    fwd(3'b111, 2'h1, 1'b0, 3'h0);
    reg_wr(lue_pkg::OFF_UNK_VID_CTRL, 32'h8000_0004);
    fwd(3'b111, 2'h1, 1'b1, 3'h4);
    reg_wr(lue_pkg::OFF_UNK_UC_CTRL, 32'h0000_0005);
    fwd(3'b011, 2'h2, 1'b0, 3'h0);
    reg_wr(lue_pkg::OFF_UNK_MC_CTRL, 32'h0000_0006);
    fwd(3'b001, 2'h3, 1'b0, 3'h0);
    fwd(3'b000, 2'h0, 1'b0, 3'h0);
    @(negedge i_sys_clk);
    i_pkt_valid = 1'b0;
    @(negedge i_sys_clk);
    chk({31'h0, o_fwd_valid}, 32'h0, "forward valid low");
    $display("test_fwd done");
  endtask

  // Reset in mid-run must clear programmed controls and captured indices.
  task automatic test_midrun_reset();
    reg_wr(lue_pkg::OFF_UNK_UC_CTRL, 32'h8000_0007);
    reg_wr(lue_pkg::OFF_UNK_MC_CTRL, 32'h8000_0007);
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk({22'h0, o_rvalid, o_rerr, o_almost_full_evt, o_fwd_valid, o_fwd_en, o_fwd_sel,
         o_fwd_ports}, 32'h0, "outputs after reset");
    chk(o_rdata, 32'h0000_0000, "read data after reset");
    reg_rd(lue_pkg::OFF_UNK_UC_CTRL, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_UNK_MC_CTRL, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_HOST_ACCESS_INDEX, 32'h0000_0000, 1'b0);
    reg_rd(lue_pkg::OFF_LEARN_FAIL_INDEX, 32'h0000_0000, 1'b0);
    $display("test_midrun_reset done");
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog so that a hung run still reaches the verdict.
  initial begin
    #400000;
    errors++;
    $display("ERROR at %0t: run did not finish in time", $time);
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    test_reset();
    test_ctrl();
    test_events();
    test_fwd();
    test_midrun_reset();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
